// file: include/spc_pkg.sv
// Package of register map, field positions and reset values for the loop and termination bank
//
// Contract
// RULE1 - Rising edge of recalibrate bit 2 reruns all loop calibration routines.
// RULE2 - Software clears recalibrate bit before requesting another recalibration.
// RULE3 - Setting enable bit 0 powers loop bias currents, then starts calibration.
// RULE4 - Software checks reference clock and divider before setting enable.
// RULE5 - Status bit 5 reads 1 while pump output is above range.
// RULE6 - Status bit 4 reads 1 while pump output is below range.
// RULE7 - Status bit 3 reads 1 only once pump calibration finished validly.
// RULE8 - Status bit 0 reads 1 while the loop is locked.
// RULE9 - Divider field bits 1:0 set reference division before the detector.
// RULE10 - Software keeps divided reference between 35 MHz and 80 MHz.
// RULE11 - Software picks divider code 00, 01 or 10 by lane rate.
// RULE12 - Rising edge of termination start bit 0 starts group calibration.
// RULE13 - Termination override field applies only to lanes 0, 1, 6, 7.
// RULE14 - Override bit 4 low selects calibrated termination, other bits ignored.
// RULE15 - Override bit 4 high forces code from bits 3:1; 000 included.
// RULE16 - Forced code follows bits 3:1 for every value, up to 111.
// RULE17 - Equalizer power field bits 7:6: 00 normal, 01 low power.
// RULE18 - Writes to read-only and reserved bits are ignored.
package spc_pkg;
  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [9:0] SPC_IDX_EQ_BIAS = 10'h268;
  localparam logic [9:0] SPC_IDX_ENABLE = 10'h280;
  localparam logic [9:0] SPC_IDX_STATUS = 10'h281;
  localparam logic [9:0] SPC_IDX_DIVIDER = 10'h289;
  localparam logic [9:0] SPC_IDX_TERM_START = 10'h2a7;
  localparam logic [9:0] SPC_IDX_TERM_OVR = 10'h2a8;
  localparam logic [9:0] SPC_IDX_IRQ_STATUS = 10'h300;
  localparam logic [9:0] SPC_IDX_IRQ_CLEAR = 10'h301;
  localparam logic [9:0] SPC_IDX_IRQ_ENABLE = 10'h302;
  // ==========================================================
  // Field positions
  localparam int SPC_BIT_ENABLE = 0;
  localparam int SPC_BIT_RECAL = 2;
  localparam int SPC_BIT_LOCK = 0;
  localparam int SPC_BIT_CAL_VALID = 3;
  localparam int SPC_BIT_BELOW = 4;
  localparam int SPC_BIT_ABOVE = 5;
  localparam int SPC_BIT_TERM_START = 0;
  localparam int SPC_BIT_FORCE = 4;
  localparam int SPC_FORCE_LSB = 1;
  localparam int SPC_EQ_LSB = 6;
  // Interrupt status layout
  localparam int SPC_IRQ_LOCK_GAINED = 0;
  localparam int SPC_IRQ_LOCK_LOST = 1;
  localparam int SPC_IRQ_CAL_VALID = 2;
  localparam int SPC_IRQ_RANGE = 3;
  localparam int SPC_IRQ_W = 4;
  // ==========================================================
  // Reset values
  localparam logic [7:0] SPC_RST_EQ_BIAS = 8'h44;
  localparam logic [7:0] SPC_RST_ENABLE = 8'h00;
  localparam logic [7:0] SPC_RST_DIVIDER = 8'h00;
  localparam logic [7:0] SPC_RST_TERM_START = 8'h00;
  localparam logic [7:0] SPC_RST_TERM_OVR = 8'h00;
  localparam logic [3:0] SPC_RST_IRQ = 4'h0;
  // Writable masks; other bits are read-only or reserved
  localparam logic [7:0] SPC_WMASK_ENABLE = 8'h07;
  localparam logic [7:0] SPC_WMASK_DIVIDER = 8'h03;
  localparam logic [7:0] SPC_WMASK_TERM_START = 8'h01;
  // ==========================================================
  // AHB-Lite encodings
  localparam logic [1:0] SPC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] SPC_HSIZE_WORD = 3'h2;
endpackage

// file: hw/spc_regs.sv
// Register bank for the lane loop and group A termination control over AHB-Lite
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module spc_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pump_above_range_in,
  input wire logic pump_below_range_in,
  input wire logic pump_cal_valid_in,
  input wire logic loop_locked_in,
  input wire logic [2:0] term_cal_code_in,
  output logic loop_power_enable,
  output logic loop_calibrate_start,
  output logic [1:0] reference_divide_select,
  output logic termination_group_a_cal_trigger,
  output logic [2:0] termination_group_a_code,
  output logic termination_group_a_forced,
  output logic [1:0] equalizer_power_select,
  output logic irq
);
  // ==========================================================
  // Register storage
  logic [7:0] eq_bias_reg;
  logic [7:0] enable_reg;
  logic [7:0] divider_reg;
  logic [7:0] term_start_reg;
  logic [7:0] term_ovr_reg;
  logic [3:0] irq_status_reg;
  logic [3:0] irq_enable_reg;
  logic [3:0] irq_status_next;
  logic [3:0] irq_event;
  logic [3:0] irq_clear;
  logic enable_prev_reg;
  logic recal_prev_reg;
  logic term_start_prev_reg;
  logic power_up_reg;
  logic [7:0] status_view;

  // ==========================================================
  // Analog status synchronisers
  // Two flops each; the first is read only by the second
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic [6:0] async_in;
  assign async_in = {term_cal_code_in, loop_locked_in, pump_cal_valid_in,
                     pump_below_range_in, pump_above_range_in};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  logic above_s;
  logic below_s;
  logic valid_s;
  logic locked_s;
  logic [2:0] cal_code_s;
  assign above_s = sync2_reg[0];
  assign below_s = sync2_reg[1];
  assign valid_s = sync2_reg[2];
  assign locked_s = sync2_reg[3];
  // Code bits may settle apart; only a value seen on two cycles running is used
  logic [2:0] code_d_reg;
  logic [2:0] cal_code_hold_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_d_reg <= 3'h0;
      cal_code_hold_reg <= 3'h0;
    end else begin
      code_d_reg <= sync2_reg[6:4];
      if (sync2_reg[6:4] == code_d_reg) begin
        cal_code_hold_reg <= code_d_reg;
      end
    end
  end
  assign cal_code_s = cal_code_hold_reg;

  // Live status view; reserved bits read zero
  always_comb begin
    status_view = 8'h00;
    status_view[spc_pkg::SPC_BIT_ABOVE] = above_s; // [RULE5]
    status_view[spc_pkg::SPC_BIT_BELOW] = below_s; // [RULE6]
    status_view[spc_pkg::SPC_BIT_CAL_VALID] = valid_s; // [RULE7]
    status_view[spc_pkg::SPC_BIT_LOCK] = locked_s; // [RULE8]
  end

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  logic addr_ok;
  logic wr_pend_reg;
  logic [9:0] wr_idx_reg;
  logic [9:0] idx;
  logic wr_go;
  assign idx = haddr[11:2];
  assign addr_ok = hsel && hready && (htrans == spc_pkg::SPC_HTRANS_NONSEQ)
                   && (hsize == spc_pkg::SPC_HSIZE_WORD) && (haddr[1:0] == 2'h0);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_go = wr_pend_reg && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 10'h000;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_idx_reg <= idx;
    end
  end

  // Read data registered at the address phase, valid in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      case (idx)
        spc_pkg::SPC_IDX_EQ_BIAS: hrdata <= {24'h000000, eq_bias_reg};
        spc_pkg::SPC_IDX_ENABLE: hrdata <= {24'h000000, enable_reg};
        spc_pkg::SPC_IDX_STATUS: hrdata <= {24'h000000, status_view};
        spc_pkg::SPC_IDX_DIVIDER: hrdata <= {24'h000000, divider_reg};
        spc_pkg::SPC_IDX_TERM_START: hrdata <= {24'h000000, term_start_reg};
        spc_pkg::SPC_IDX_TERM_OVR: hrdata <= {24'h000000, term_ovr_reg};
        spc_pkg::SPC_IDX_IRQ_STATUS: hrdata <= {28'h0000000, irq_status_reg};
        spc_pkg::SPC_IDX_IRQ_ENABLE: hrdata <= {28'h0000000, irq_enable_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Writable registers; masks drop read-only and reserved bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eq_bias_reg <= spc_pkg::SPC_RST_EQ_BIAS;
      enable_reg <= spc_pkg::SPC_RST_ENABLE;
      divider_reg <= spc_pkg::SPC_RST_DIVIDER;
      term_start_reg <= spc_pkg::SPC_RST_TERM_START;
      term_ovr_reg <= spc_pkg::SPC_RST_TERM_OVR;
      irq_enable_reg <= spc_pkg::SPC_RST_IRQ;
    end else if (wr_go) begin
      case (wr_idx_reg)
        spc_pkg::SPC_IDX_EQ_BIAS: eq_bias_reg <= hwdata[7:0]; // [RULE17]
        spc_pkg::SPC_IDX_ENABLE: enable_reg <= hwdata[7:0] & spc_pkg::SPC_WMASK_ENABLE; // [RULE18]
        spc_pkg::SPC_IDX_DIVIDER: divider_reg <= hwdata[7:0] & spc_pkg::SPC_WMASK_DIVIDER; // [RULE18]
        spc_pkg::SPC_IDX_TERM_START: begin
          term_start_reg <= hwdata[7:0] & spc_pkg::SPC_WMASK_TERM_START; // [RULE18]
        end
        spc_pkg::SPC_IDX_TERM_OVR: term_ovr_reg <= hwdata[7:0];
        spc_pkg::SPC_IDX_IRQ_ENABLE: irq_enable_reg <= hwdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Loop enable and calibration sequencing
  // Bias goes up first; calibration is launched one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_prev_reg <= 1'b0;
      recal_prev_reg <= 1'b0;
      term_start_prev_reg <= 1'b0;
      power_up_reg <= 1'b0;
      loop_calibrate_start <= 1'b0;
      termination_group_a_cal_trigger <= 1'b0;
    end else begin
      enable_prev_reg <= enable_reg[spc_pkg::SPC_BIT_ENABLE];
      recal_prev_reg <= enable_reg[spc_pkg::SPC_BIT_RECAL];
      term_start_prev_reg <= term_start_reg[spc_pkg::SPC_BIT_TERM_START];
      power_up_reg <= enable_reg[spc_pkg::SPC_BIT_ENABLE] && !enable_prev_reg; // [RULE3]
      // Holding the bit high does not repeat; a fresh edge is needed
      loop_calibrate_start <= power_up_reg ||
        (enable_reg[spc_pkg::SPC_BIT_RECAL] && !recal_prev_reg); // [RULE1] [RULE2]
      termination_group_a_cal_trigger <= term_start_reg[spc_pkg::SPC_BIT_TERM_START]
        && !term_start_prev_reg; // [RULE12]
    end
  end

  // ==========================================================
  // Steering outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loop_power_enable <= 1'b0;
      reference_divide_select <= 2'h0;
      equalizer_power_select <= spc_pkg::SPC_RST_EQ_BIAS[7:6];
      termination_group_a_code <= 3'h0;
      termination_group_a_forced <= 1'b0;
    end else begin
      loop_power_enable <= enable_reg[spc_pkg::SPC_BIT_ENABLE]; // [RULE3]
      reference_divide_select <= divider_reg[1:0]; // [RULE9]
      equalizer_power_select <= eq_bias_reg[spc_pkg::SPC_EQ_LSB +: 2]; // [RULE17]
      // Only lanes 0, 1, 6, 7 see this code [RULE13]
      termination_group_a_forced <= term_ovr_reg[spc_pkg::SPC_BIT_FORCE];
      if (term_ovr_reg[spc_pkg::SPC_BIT_FORCE]) begin
        termination_group_a_code <= term_ovr_reg[spc_pkg::SPC_FORCE_LSB +: 3]; // [RULE15] [RULE16]
      end else begin
        termination_group_a_code <= cal_code_s; // [RULE14]
      end
    end
  end

  // ==========================================================
  // Interrupts: sticky status, write-one clear, set beats clear
  logic locked_d_reg;
  logic valid_d_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      locked_d_reg <= 1'b0;
      valid_d_reg <= 1'b0;
    end else begin
      locked_d_reg <= locked_s;
      valid_d_reg <= valid_s;
    end
  end

  always_comb begin
    irq_event = 4'h0;
    irq_event[spc_pkg::SPC_IRQ_LOCK_GAINED] = locked_s && !locked_d_reg;
    irq_event[spc_pkg::SPC_IRQ_LOCK_LOST] = !locked_s && locked_d_reg;
    irq_event[spc_pkg::SPC_IRQ_CAL_VALID] = valid_s && !valid_d_reg;
    irq_event[spc_pkg::SPC_IRQ_RANGE] = above_s || below_s;
    irq_clear = (wr_go && wr_idx_reg == spc_pkg::SPC_IDX_IRQ_CLEAR) ? hwdata[3:0] : 4'h0;
    irq_status_next = (irq_status_reg & ~irq_clear) | irq_event;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_reg <= spc_pkg::SPC_RST_IRQ;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  assign irq = |(irq_status_reg & irq_enable_reg);

  // ==========================================================
  // Assertions
  sequence s_enable_rise;
    enable_reg[spc_pkg::SPC_BIT_ENABLE] && !enable_prev_reg;
  endsequence

  sequence s_recal_rise;
    enable_reg[spc_pkg::SPC_BIT_RECAL] && !recal_prev_reg;
  endsequence

  a_recal_starts_cal: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE1]
    s_recal_rise |=> loop_calibrate_start)
    else $error("recalibrate edge did not start calibration");

  a_recal_held_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE2]
    (enable_reg[spc_pkg::SPC_BIT_RECAL] && recal_prev_reg && !power_up_reg)
    |=> !loop_calibrate_start)
    else $error("held recalibrate bit retriggered calibration");

  a_enable_power_cal: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE3]
    s_enable_rise |=> loop_power_enable ##1 loop_calibrate_start)
    else $error("enable did not power up then calibrate");

  a_status_above: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE5]
    addr_ok && !hwrite && idx == spc_pkg::SPC_IDX_STATUS
    |=> hrdata[spc_pkg::SPC_BIT_ABOVE] == $past(above_s))
    else $error("above-range status wrong");

  a_status_below: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE6]
    $rose(pump_below_range_in) ##1 pump_below_range_in ##1 pump_below_range_in
    |-> status_view[spc_pkg::SPC_BIT_BELOW])
    else $error("below-range status missed");

  a_status_valid: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE7]
    !pump_cal_valid_in [*3] |-> !status_view[spc_pkg::SPC_BIT_CAL_VALID])
    else $error("calibration valid shown without cause");

  a_status_lock: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE8]
    loop_locked_in [*3] |-> status_view[spc_pkg::SPC_BIT_LOCK])
    else $error("lock status not shown");

  a_divider_drive: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE9]
    wr_go && wr_idx_reg == spc_pkg::SPC_IDX_DIVIDER
    |=> ##1 reference_divide_select == $past(hwdata[1:0], 2))
    else $error("divider output not updated");

  a_term_trigger: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE12]
    $rose(term_start_reg[spc_pkg::SPC_BIT_TERM_START]) |=> termination_group_a_cal_trigger
    ##1 !termination_group_a_cal_trigger)
    else $error("termination trigger not a single pulse");

  a_term_forced: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE15]
    term_ovr_reg[spc_pkg::SPC_BIT_FORCE] |=> termination_group_a_code
    == $past(term_ovr_reg[spc_pkg::SPC_FORCE_LSB +: 3]))
    else $error("forced termination code wrong");

  a_term_auto: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE14]
    !term_ovr_reg[spc_pkg::SPC_BIT_FORCE] |=> termination_group_a_code == $past(cal_code_s)
    && !termination_group_a_forced)
    else $error("auto termination code not used");

  a_eq_mode: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE17]
    ##1 equalizer_power_select == $past(eq_bias_reg[7:6]))
    else $error("equalizer mode not driven");

  a_ro_ignored: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE18]
    ##1 (enable_reg[7:3] == 5'h00) && (divider_reg[7:2] == 6'h00)
    && (term_start_reg[7:1] == 7'h00))
    else $error("reserved bits took a write");

  // ==========================================================
  // Interrupt and readback checks
  // A pin held for three samples has crossed both flops
  sequence s_lock_pin_rise;
    $rose(loop_locked_in) ##1 loop_locked_in ##1 loop_locked_in;
  endsequence

  a_lock_gain_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    s_lock_pin_rise |=> irq_status_reg[spc_pkg::SPC_IRQ_LOCK_GAINED])
    else $error("lock gain not latched");

  a_irq_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_event != 4'h0 |=> (irq_status_reg & $past(irq_event)) == $past(irq_event))
    else $error("interrupt event lost");

  a_irq_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 (irq_status_reg & $past(irq_status_reg) & ~$past(irq_clear))
    == ($past(irq_status_reg) & ~$past(irq_clear)))
    else $error("interrupt status dropped without clear");

  a_irq_clear_works: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_go && (wr_idx_reg == spc_pkg::SPC_IDX_IRQ_CLEAR)
    |=> (irq_status_reg & $past(irq_clear) & ~$past(irq_event)) == 4'h0)
    else $error("interrupt clear ignored");

  a_range_relevel: assert property (@(posedge hclk) disable iff (!hresetn)
    (above_s || below_s) |=> irq_status_reg[spc_pkg::SPC_IRQ_RANGE])
    else $error("range fault not latched");

  a_ovr_readback: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE13]
    addr_ok && !hwrite && (idx == spc_pkg::SPC_IDX_TERM_OVR)
    |=> hrdata == {24'h000000, $past(term_ovr_reg)})
    else $error("override readback wrong");
endmodule // spc_regs

// file: verif/serdes_pll_term_cal_ctrl_tb_top.sv
// Self-checking bench for the loop and termination register bank
`timescale 1ns/1ps
module serdes_pll_term_cal_ctrl_tb_top;
  // ==========================================================
  // Signals
  logic hclk, hresetn, hsel, hwrite;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, v, rdv;
  wire logic hready;
  logic hreadyout, hresp, irq;
  logic pump_above_range_in, pump_below_range_in, pump_cal_valid_in, loop_locked_in;
  logic [2:0] term_cal_code_in, termination_group_a_code;
  logic loop_power_enable, loop_calibrate_start, termination_group_a_cal_trigger;
  logic termination_group_a_forced;
  logic [1:0] reference_divide_select, equalizer_power_select;
  integer seed;
  int i, c0, fails, comparisons, cycles, cal_cnt, trig_cnt;

  assign hready = hreadyout;

  spc_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pump_above_range_in(pump_above_range_in), .pump_below_range_in(pump_below_range_in),
    .pump_cal_valid_in(pump_cal_valid_in), .loop_locked_in(loop_locked_in),
    .term_cal_code_in(term_cal_code_in), .loop_power_enable(loop_power_enable),
    .loop_calibrate_start(loop_calibrate_start),
    .reference_divide_select(reference_divide_select),
    .termination_group_a_cal_trigger(termination_group_a_cal_trigger),
    .termination_group_a_code(termination_group_a_code),
    .termination_group_a_forced(termination_group_a_forced),
    .equalizer_power_select(equalizer_power_select), .irq(irq));

  // ==========================================================
  // Clock, pulse counters, timeout
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Pulses are counted, not sampled, so latency slips still show as a count
  always @(posedge hclk) begin
    cycles++;
    if (loop_calibrate_start === 1'b1) cal_cnt++;
    if (termination_group_a_cal_trigger === 1'b1) trig_cnt++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Tasks and expectations
  task tally_and_finish();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single word transfer; only the bench timeout ends a wait
  task xfer(input logic w, input logic [9:0] idx, input logic [31:0] wd,
            output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= spc_pkg::SPC_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? wd : ~wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask

  task wr(input logic [9:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d, rdv);
  endtask

  task rdchk(input logic [9:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0, rdv);
    chk(rdv, exp);
  endtask

  function automatic logic [31:0] exp_status(input logic [3:0] s);
    return {26'h0, s[3], s[2], s[1], 2'b00, s[0]};
  endfunction

  function automatic logic [2:0] exp_code(input logic [7:0] ov, input logic [2:0] cal);
    return ov[4] ? ov[3:1] : cal;
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    seed = 40532;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = spc_pkg::SPC_HSIZE_WORD;
    {pump_above_range_in, pump_below_range_in, pump_cal_valid_in, loop_locked_in} = 4'h0;
    term_cal_code_in = 3'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(equalizer_power_select, 2'b01);
    rdchk(spc_pkg::SPC_IDX_EQ_BIAS, 32'h44);
    rdchk(spc_pkg::SPC_IDX_ENABLE, 32'h0);
    rdchk(spc_pkg::SPC_IDX_STATUS, 32'h0);
    rdchk(spc_pkg::SPC_IDX_DIVIDER, 32'h0);
    rdchk(spc_pkg::SPC_IDX_TERM_START, 32'h0);
    rdchk(spc_pkg::SPC_IDX_TERM_OVR, 32'h0);
    rdchk(spc_pkg::SPC_IDX_IRQ_ENABLE, 32'h0);
    wr(10'h3ff, 32'hffffffff);
    rdchk(10'h3ff, 32'h0);
    // Divider set before enable; code 00 keeps the divided reference in range
    wr(spc_pkg::SPC_IDX_DIVIDER, 32'h0);
    // Enable with recal low, reserved upper bits written too
    c0 = cal_cnt;
    wr(spc_pkg::SPC_IDX_ENABLE, 32'hfb);
    repeat (4) @(posedge hclk);
    chk(loop_power_enable, 1'b1);
    chk(cal_cnt - c0, 1);
    rdchk(spc_pkg::SPC_IDX_ENABLE, 32'h03);
    c0 = cal_cnt;
    wr(spc_pkg::SPC_IDX_ENABLE, 32'h05);
    repeat (3) @(posedge hclk);
    chk(cal_cnt - c0, 1);
    wr(spc_pkg::SPC_IDX_ENABLE, 32'h05);
    repeat (3) @(posedge hclk);
    chk(cal_cnt - c0, 1);
    wr(spc_pkg::SPC_IDX_ENABLE, 32'h01);
    wr(spc_pkg::SPC_IDX_ENABLE, 32'h05);
    repeat (3) @(posedge hclk);
    chk(cal_cnt - c0, 2);
    wr(spc_pkg::SPC_IDX_ENABLE, 32'h00);
    repeat (3) @(posedge hclk);
    chk(loop_power_enable, 1'b0);
    // Code 11 has no lane rate, so the walk wraps back to 00
    for (i = 0; i < 4; i++) begin
      v = i % 3;
      wr(spc_pkg::SPC_IDX_DIVIDER, 32'hfc | v);
      repeat (2) @(posedge hclk);
      chk(reference_divide_select, v[1:0]);
      rdchk(spc_pkg::SPC_IDX_DIVIDER, v);
    end
    c0 = trig_cnt;
    wr(spc_pkg::SPC_IDX_TERM_START, 32'hff);
    repeat (3) @(posedge hclk);
    chk(trig_cnt - c0, 1);
    rdchk(spc_pkg::SPC_IDX_TERM_START, 32'h01);
    wr(spc_pkg::SPC_IDX_TERM_START, 32'h01);
    wr(spc_pkg::SPC_IDX_TERM_START, 32'h00);
    wr(spc_pkg::SPC_IDX_TERM_START, 32'h01);
    repeat (3) @(posedge hclk);
    chk(trig_cnt - c0, 2);
    // First eight passes walk every forced code, the rest are random
    for (i = 0; i < 16; i++) begin
      v = $random(seed);
      if (i < 8) v[4:1] = {1'b1, i[2:0]};
      term_cal_code_in <= v[10:8];
      wr(spc_pkg::SPC_IDX_TERM_OVR, v);
      repeat (4) @(posedge hclk);
      chk(termination_group_a_code, exp_code(v[7:0], v[10:8]));
      chk(termination_group_a_forced, v[4]);
      rdchk(spc_pkg::SPC_IDX_TERM_OVR, {24'h0, v[7:0]});
    end
    for (i = 0; i < 2; i++) begin
      wr(spc_pkg::SPC_IDX_EQ_BIAS, {24'h0, i[1:0], 6'h04});
      repeat (2) @(posedge hclk);
      chk(equalizer_power_select, i[1:0]);
    end
    for (i = 0; i < 10; i++) begin
      v = $random(seed);
      {pump_above_range_in, pump_below_range_in, pump_cal_valid_in, loop_locked_in} <= v[3:0];
      repeat (3) @(posedge hclk);
      rdchk(spc_pkg::SPC_IDX_STATUS, exp_status(v[3:0]));
    end
    wr(spc_pkg::SPC_IDX_STATUS, 32'hff);
    rdchk(spc_pkg::SPC_IDX_STATUS, exp_status(v[3:0]));
    // Interrupt: raise, mask, clear
    {pump_above_range_in, pump_below_range_in, pump_cal_valid_in, loop_locked_in} <= 4'h0;
    repeat (5) @(posedge hclk);
    wr(spc_pkg::SPC_IDX_IRQ_CLEAR, 32'hf);
    wr(spc_pkg::SPC_IDX_IRQ_ENABLE, 32'h1);
    rdchk(spc_pkg::SPC_IDX_IRQ_STATUS, 32'h0);
    chk(irq, 1'b0);
    loop_locked_in <= 1'b1;
    repeat (5) @(posedge hclk);
    chk(irq, 1'b1);
    rdchk(spc_pkg::SPC_IDX_IRQ_STATUS, 32'h1);
    wr(spc_pkg::SPC_IDX_IRQ_CLEAR, 32'h1);
    @(posedge hclk);
    chk(irq, 1'b0);
    loop_locked_in <= 1'b0;
    repeat (5) @(posedge hclk);
    chk(irq, 1'b0);
    rdchk(spc_pkg::SPC_IDX_IRQ_STATUS, 32'h2);
    wr(spc_pkg::SPC_IDX_IRQ_ENABLE, 32'h2);
    @(posedge hclk);
    chk(irq, 1'b1);
    tally_and_finish();
  end
endmodule // serdes_pll_term_cal_ctrl_tb_top
